// [hw/bpp_line.v]
// One port line: output latch, direction, open-drain select and input path.
`timescale 1ns/1ps
`include "bpp_regs.vh"
module bpp_line #(
   parameter OD_OK = 1
) (
   // Clock and reset
   input  wire clk_sys,
   input  wire rst,
   // Register writes
   input  wire ld_latch,
   input  wire latch_d,
   input  wire ld_dir,
   input  wire dir_d,
   input  wire ld_od,
   input  wire od_d,
   // Alternate function and hardware direction
   input  wire alt_sel,
   input  wire alt_data,
   input  wire alt_auto,
   input  wire hw_dir_en,
   input  wire hw_dir,
   // Pin
   input  wire pin_i,
   output wire pin_o,
   output wire pin_oe,
   // State seen by software and peripherals
   output wire rd_val,
   output wire alt_in,
   output wire dir_q,
   output wire od_q
);
   reg  latch_ff;
   reg  dir_ff;
   reg  od_ff;
   reg  sync1_ff;
   reg  sync2_ff;
   reg  in_ff;
   wire eff_dir;
   wire drive_val;
   wire driving;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         latch_ff <= `BPP_RST_LATCH;
         dir_ff   <= `BPP_RST_DIR;
         od_ff    <= `BPP_RST_OD;
      end else begin
         if (ld_latch) begin
            latch_ff <= latch_d;
         end
         if (ld_dir) begin
            dir_ff <= dir_d;
         end
         if (ld_od && (OD_OK != 0)) begin
            od_ff <= od_d;
         end
      end
   end

   // The first stage feeds only the second; the input latch takes stage two.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1_ff <= 1'h0;
         sync2_ff <= 1'h0;
         in_ff    <= 1'h0;
      end else begin
         sync1_ff <= pin_i;
         sync2_ff <= sync1_ff;
         in_ff    <= sync2_ff;
      end
   end

   // The external bus logic owns the direction while it is enabled.
   assign eff_dir   = hw_dir_en ? hw_dir : dir_ff;
   assign drive_val = alt_sel ? (latch_ff & alt_data) : latch_ff;
   assign driving   = eff_dir | (alt_sel & alt_auto);
   // In open-drain mode a high level is left to the external pullup.
   assign pin_oe    = driving & ~(od_ff & drive_val);
   assign pin_o     = drive_val;
   assign rd_val    = eff_dir ? latch_ff : in_ff;
   assign alt_in    = eff_dir ? latch_ff : in_ff;
   assign dir_q     = dir_ff;
   assign od_q      = od_ff;
endmodule

// [hw/bpp_regs.vh]
// Constants for the bidirectional parallel port lines block.
`ifndef BPP_REGS_VH
`define BPP_REGS_VH

// Line and port counts.
`define BPP_LINES        72
`define BPP_PORTS        9
`define BPP_LINE_W       8
`define BPP_PORT_W       4
`define BPP_REG_W        3
`define BPP_ADR_W        12

// First line of each port in the flat line vector.
`define BPP_BASE_P0L     0
`define BPP_BASE_P0H     8
`define BPP_BASE_P1L     16
`define BPP_BASE_P1H     24
`define BPP_BASE_P2      32
`define BPP_BASE_P3      40
`define BPP_BASE_P4      51
`define BPP_BASE_P6      58
`define BPP_BASE_P7      66

// Port numbers as seen in the port address field.
`define BPP_PORT_P0L     0
`define BPP_PORT_P0H     1
`define BPP_PORT_P1L     2
`define BPP_PORT_P1H     3
`define BPP_PORT_P2      4
`define BPP_PORT_P3      5
`define BPP_PORT_P4      6
`define BPP_PORT_P6      7
`define BPP_PORT_P7      8

// Byte address layout: port area at 0x000, one bit per word at 0x400.
`define BPP_AREA_BIT     10
`define BPP_PORT_HI      8
`define BPP_PORT_LO      5
`define BPP_REG_HI       4
`define BPP_REG_LO       2
`define BPP_LINE_HI      9
`define BPP_LINE_LO      2
`define BPP_PORT_STRIDE  12'h020
`define BPP_BIT_AREA     12'h400

// Register index inside a port block (byte offset is four times this).
`define BPP_REG_DATA     3'h0
`define BPP_REG_DIR      3'h1
`define BPP_REG_OD       3'h2
`define BPP_REG_SET      3'h3
`define BPP_REG_CLR      3'h4
`define BPP_REG_TGL      3'h5

// Reset values of the per-line state.
`define BPP_RST_LATCH    1'h0
`define BPP_RST_DIR      1'h0
`define BPP_RST_OD       1'h0

// Lanes within the 16-bit port word.
`define BPP_LANE_SPLIT   8

`endif

// [hw/bpp_top.v]
// Parallel port lines with a classic Wishbone register slave.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "bpp_regs.vh"

module bpp_top (
   // Clock and reset
   input  wire                     clk_sys,
   input  wire                     rst,
   // Wishbone slave
   input  wire [`BPP_ADR_W-1:0]    wb_adr_i,
   input  wire [31:0]              wb_dat_i,
   output wire [31:0]              wb_dat_o,
   input  wire [3:0]               wb_sel_i,
   input  wire                     wb_we_i,
   input  wire                     wb_cyc_i,
   input  wire                     wb_stb_i,
   output wire                     wb_ack_o,
   // Pins
   input  wire [`BPP_LINES-1:0]    pin_i,
   output wire [`BPP_LINES-1:0]    pin_o,
   output wire [`BPP_LINES-1:0]    pin_oe,
   // Alternate functions
   input  wire [`BPP_LINES-1:0]    alt_sel_i,
   input  wire [`BPP_LINES-1:0]    alt_data_i,
   input  wire [`BPP_LINES-1:0]    alt_auto_i,
   output wire [`BPP_LINES-1:0]    alt_in_o,
   // Multiplexed external bus on port 0
   input  wire                     bus_en_i,
   input  wire                     bus_wide_i,
   input  wire [15:0]              bus_drive_i
);

   // Port number of a flat line index.
   function integer port_of;
      input integer i;
      begin
         if (i < `BPP_BASE_P0H)
            port_of = `BPP_PORT_P0L;
         else if (i < `BPP_BASE_P1L)
            port_of = `BPP_PORT_P0H;
         else if (i < `BPP_BASE_P1H)
            port_of = `BPP_PORT_P1L;
         else if (i < `BPP_BASE_P2)
            port_of = `BPP_PORT_P1H;
         else if (i < `BPP_BASE_P3)
            port_of = `BPP_PORT_P2;
         else if (i < `BPP_BASE_P4)
            port_of = `BPP_PORT_P3;
         else if (i < `BPP_BASE_P6)
            port_of = `BPP_PORT_P4;
         else if (i < `BPP_BASE_P7)
            port_of = `BPP_PORT_P6;
         else
            port_of = `BPP_PORT_P7;
      end
   endfunction

   // First flat line of a port.
   function integer base_of;
      input integer p;
      begin
         case (p)
            `BPP_PORT_P0L: base_of = `BPP_BASE_P0L;
            `BPP_PORT_P0H: base_of = `BPP_BASE_P0H;
            `BPP_PORT_P1L: base_of = `BPP_BASE_P1L;
            `BPP_PORT_P1H: base_of = `BPP_BASE_P1H;
            `BPP_PORT_P2:  base_of = `BPP_BASE_P2;
            `BPP_PORT_P3:  base_of = `BPP_BASE_P3;
            `BPP_PORT_P4:  base_of = `BPP_BASE_P4;
            `BPP_PORT_P6:  base_of = `BPP_BASE_P6;
            default:       base_of = `BPP_BASE_P7;
         endcase
      end
   endfunction

   reg                         ack_ff;
   reg  [31:0]                 dat_ff;
   reg  [31:0]                 nxt_dat;
   wire                        req;
   wire                        wr_fire;
   wire                        bit_area;
   wire [`BPP_PORT_W-1:0]      adr_port;
   wire [`BPP_REG_W-1:0]       adr_reg;
   wire [`BPP_LINE_W-1:0]      adr_line;
   wire [`BPP_LINES-1:0]       rd_vec;
   wire [`BPP_LINES-1:0]       dir_vec;
   wire [`BPP_LINES-1:0]       od_vec;
   integer                     i;

   assign req      = wb_cyc_i & wb_stb_i;
   // A write lands on the edge at which the master sees ack high.
   assign wr_fire  = req & wb_we_i & ack_ff;
   assign bit_area = wb_adr_i[`BPP_AREA_BIT];
   assign adr_port = wb_adr_i[`BPP_PORT_HI:`BPP_PORT_LO];
   assign adr_reg  = wb_adr_i[`BPP_REG_HI:`BPP_REG_LO];
   assign adr_line = wb_adr_i[`BPP_LINE_HI:`BPP_LINE_LO];

   // Every access, mapped or not, is answered one cycle after it starts.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_ff <= 1'h0;
         dat_ff <= 32'h0;
      end else begin
         ack_ff <= req & ~ack_ff;
         if (req & ~ack_ff) begin
            dat_ff <= nxt_dat;
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   // Read data: a 16-bit port word or a single line in bit 0.
   always @* begin
      nxt_dat = 32'h0;
      if (bit_area) begin
         for (i = 0; i < `BPP_LINES; i = i + 1) begin
            if (adr_line == i[`BPP_LINE_W-1:0]) begin
               nxt_dat[0] = rd_vec[i];
            end
         end
      end else begin
         for (i = 0; i < `BPP_LINES; i = i + 1) begin
            if (adr_port == port_of(i)) begin
               case (adr_reg)
                  `BPP_REG_DATA,
                  `BPP_REG_SET,
                  `BPP_REG_CLR,
                  `BPP_REG_TGL:
                     nxt_dat[i - base_of(port_of(i))] = rd_vec[i];
                  `BPP_REG_DIR:
                     nxt_dat[i - base_of(port_of(i))] = dir_vec[i];
                  `BPP_REG_OD:
                     nxt_dat[i - base_of(port_of(i))] = od_vec[i];
                  default:
                     nxt_dat[0] = nxt_dat[0];
               endcase
            end
         end
      end
   end

   // One cell per line; widths and positions follow the port layout.
   genvar g;
   generate
      for (g = 0; g < `BPP_LINES; g = g + 1) begin : g_line
         localparam integer PRT = port_of(g);
         localparam integer BIT = g - base_of(port_of(g));
         localparam integer OD_OK = (PRT == `BPP_PORT_P0L) ? 0 : 1;
         wire phit;
         wire lhit;
         wire lane;
         wire wd;
         wire ld_latch;
         wire ld_dir;
         wire ld_od;
         reg  latch_d;
         wire hw_dir_en;
         wire hw_dir;

         assign phit = ~bit_area & (adr_port == PRT);
         assign lhit = bit_area & (adr_line == g);
         assign lane = (BIT < `BPP_LANE_SPLIT) ? wb_sel_i[0] : wb_sel_i[1];
         assign wd   = wb_dat_i[BIT];

         // Read-modify-write starts from what a read would return.
         always @* begin
            case (adr_reg)
               `BPP_REG_SET: latch_d = rd_vec[g] | wd;
               `BPP_REG_CLR: latch_d = rd_vec[g] & ~wd;
               `BPP_REG_TGL: latch_d = rd_vec[g] ^ wd;
               default:      latch_d = wd;
            endcase
            if (lhit) begin
               latch_d = wb_dat_i[0];
            end
         end

         assign ld_latch = wr_fire & ((phit & lane &
                           (adr_reg == `BPP_REG_DATA ||
                            adr_reg == `BPP_REG_SET ||
                            adr_reg == `BPP_REG_CLR ||
                            adr_reg == `BPP_REG_TGL)) |
                           (lhit & wb_sel_i[0]));
         assign ld_dir = wr_fire & phit & lane &
                         (adr_reg == `BPP_REG_DIR);
         assign ld_od  = wr_fire & phit & lane &
                         (adr_reg == `BPP_REG_OD);

         // Port 0 low half follows the bus engine while the bus is active; the high half only in wide mode.
         if (g < `BPP_BASE_P0H) begin : g_lo
            assign hw_dir_en = bus_en_i;
            assign hw_dir    = bus_drive_i[g];
         end else if (g < `BPP_BASE_P1L) begin : g_hi
            assign hw_dir_en = bus_en_i & bus_wide_i;
            assign hw_dir    = bus_drive_i[g];
         end else begin : g_gp
            assign hw_dir_en = 1'h0;
            assign hw_dir    = 1'h0;
         end

         bpp_line #(
            .OD_OK     (OD_OK)
         ) u_line (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .ld_latch  (ld_latch),
            .latch_d   (latch_d),
            .ld_dir    (ld_dir),
            .dir_d     (wd),
            .ld_od     (ld_od),
            .od_d      (wd),
            .alt_sel   (alt_sel_i[g]),
            .alt_data  (alt_data_i[g]),
            .alt_auto  (alt_auto_i[g]),
            .hw_dir_en (hw_dir_en),
            .hw_dir    (hw_dir),
            .pin_i     (pin_i[g]),
            .pin_o     (pin_o[g]),
            .pin_oe    (pin_oe[g]),
            .rd_val    (rd_vec[g]),
            .alt_in    (alt_in_o[g]),
            .dir_q     (dir_vec[g]),
            .od_q      (od_vec[g])
         );
      end
   endgenerate

endmodule

// [tb/bpp_pin_model.sv]
// Pin-side partner: external drivers on a wired-AND net with pull-ups.
`timescale 1ns/1ps
module bpp_pin_model (
   // Design side
   input  wire [71:0] pin_o,
   input  wire [71:0] pin_oe,
   // External devices
   input  wire [71:0] ext_drv,
   input  wire [71:0] ext_val,
   output wire [71:0] pin_i
);
   // A released line floats to the pull-up; any driver may pull it low.
   assign pin_i = (~pin_oe | pin_o) & (~ext_drv | ext_val);
endmodule

// [tb/bpp_top_monitor.sv]
// Concurrent checks on the ports of the parallel port block.
`timescale 1ns/1ps
module bpp_top_monitor (
   // Clock, reset and bus answer
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_ack_o,
   input  wire [31:0] wb_dat_o,
   // Pins and alternate functions
   input  wire [71:0] pin_i,
   input  wire [71:0] pin_o,
   input  wire [71:0] pin_oe,
   input  wire [71:0] alt_sel_i,
   input  wire [71:0] alt_data_i,
   input  wire [71:0] alt_auto_i,
   input  wire [71:0] alt_in_o,
   input  wire        bus_en_i,
   input  wire        bus_wide_i,
   input  wire [15:0] bus_drive_i
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   chk_ack_once: assert property (s_req |=> s_ack)
      else $error("ack not a single pulse");
   chk_ack_cause: assert property ($rose(wb_ack_o) |->
      $past(wb_cyc_i) && $past(wb_stb_i)) else $error("stray ack");
   chk_dat_high: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
      else $error("upper read bits set");
   chk_alt_and: assert property ((pin_o & alt_sel_i & ~alt_data_i) == '0)
      else $error("alt data not ANDed");
   chk_alt_auto: assert property (
      (alt_sel_i & alt_auto_i & ~pin_o & ~pin_oe) == '0)
      else $error("auto alt not driven");
   chk_bus_low: assert property (bus_en_i |-> pin_oe[7:0] ==
      (bus_drive_i[7:0] | alt_sel_i[7:0] & alt_auto_i[7:0]))
      else $error("bus direction low half");
   chk_bus_wide: assert property (bus_en_i && bus_wide_i |->
      (bus_drive_i[15:8] & ~pin_o[15:8] & ~pin_oe[15:8]) == 8'h0)
      else $error("bus direction high half");
   chk_out_loop: assert property (
      (pin_oe & ~alt_sel_i & (alt_in_o ^ pin_o)) == '0)
      else $error("alt input not from latch");
   chk_in_sample: assert property (
      !$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3) |->
      ((alt_in_o ^ $past(pin_i, 3)) & ~pin_oe & ~pin_o & ~alt_sel_i) == '0)
      else $error("input latch delay");
   chk_rst_state: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst && !bus_en_i |-> pin_oe == (alt_sel_i & alt_auto_i))
      else $error("reset state drives");
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the parallel port lines block.
`timescale 1ns/1ps
`include "bpp_regs.vh"
module tb_top;
   logic        clk_sys = 0;
   logic        rst = 1;
   logic [11:0] wb_adr_i = '0;
   logic [31:0] wb_dat_i = '0;
   logic [3:0]  wb_sel_i = '0;
   logic        wb_we_i = 0;
   logic        wb_cyc_i = 0;
   logic        wb_stb_i = 0;
   logic        bus_en_i = 0;
   logic        bus_wide_i = 0;
   logic [15:0] bus_drive_i = '0;
   logic [71:0] alt_sel_i = '0;
   logic [71:0] alt_data_i = '0;
   logic [71:0] alt_auto_i = '0;
   logic [71:0] ext_drv = '0;
   logic [71:0] ext_val = '0;
   logic [71:0] m_lat = '0;
   logic [71:0] m_dir = '0;
   logic [71:0] m_od = '0;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o;
   wire  [71:0] pin_i, pin_o, pin_oe, alt_in_o;
   integer      seed = 32'h9c778b36;
   int          n_fail = 0;
   int          total_checks = 0;
   int          bs[9] = '{0, 8, 16, 24, 32, 40, 51, 58, 66};
   int          wd[9] = '{8, 8, 8, 8, 8, 11, 7, 8, 6};
   always #5 clk_sys = ~clk_sys;
   bpp_top dut (.clk_sys(clk_sys), .rst(rst), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
      .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
      .alt_sel_i(alt_sel_i), .alt_data_i(alt_data_i),
      .alt_auto_i(alt_auto_i), .alt_in_o(alt_in_o), .bus_en_i(bus_en_i),
      .bus_wide_i(bus_wide_i), .bus_drive_i(bus_drive_i));
   bpp_pin_model pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_drv(ext_drv),
      .ext_val(ext_val), .pin_i(pin_i));
   function automatic logic [71:0] r72();
      logic [95:0] t;
      t = {$random(seed), $random(seed), $random(seed)};
      return t[71:0];
   endfunction
   // While the bus is enabled it owns the port 0 low directions, and the high half in wide mode.
   function automatic logic [71:0] edir();
      logic [71:0] e;
      e = m_dir;
      if (bus_en_i) e[7:0] = bus_drive_i[7:0];
      if (bus_en_i && bus_wide_i) e[15:8] = bus_drive_i[15:8];
      return e;
   endfunction
   function automatic logic [71:0] po();
      return m_lat & (~alt_sel_i | alt_data_i);
   endfunction
   function automatic logic [71:0] oe();
      return (edir() | alt_sel_i & alt_auto_i) & ~(m_od & po());
   endfunction
   function automatic logic [71:0] rv();
      logic [71:0] e;
      e = edir();
      return (e & m_lat) | (~e & (~oe() | po()) & (~ext_drv | ext_val));
   endfunction
   function automatic logic [15:0] ex(logic [71:0] v, int p);
      return 16'(v >> bs[p]) & 16'((1 << wd[p]) - 1);
   endfunction
   task automatic wb(input logic w, input logic [11:0] a,
         input logic [15:0] d, input logic [1:0] s, output logic [15:0] q);
      @(posedge clk_sys);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {16'h0, d};
      wb_sel_i <= {2'b00, s};
      @(posedge clk_sys iff wb_ack_o === 1'b1);
      q = wb_dat_o[15:0];
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask
   task automatic cmpr(input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmpp(input logic [71:0] e, input logic [71:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic settle();
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic chk_all(int p);
      logic [15:0] q;
      cmpp(po(), pin_o);
      cmpp(oe(), pin_oe);
      cmpp(rv(), alt_in_o);
      wb(0, 12'(p * 32), 0, 3, q);
      cmpr(ex(rv(), p), q);
      wb(0, 12'(p * 32 + 4), 0, 3, q);
      cmpr(ex(m_dir, p), q);
      wb(0, 12'(p * 32 + 8), 0, 3, q);
      cmpr(ex(m_od, p), q);
      wb(0, 12'(p * 32 + 24), 0, 3, q);
      cmpr(16'h0, q);
   endtask
   task automatic step(bit bus);
      int p, op, i, j;
      logic [15:0] d, q;
      logic [1:0] s;
      logic [71:0] r;
      @(posedge clk_sys);
      alt_sel_i <= r72() & r72() & r72();
      alt_data_i <= r72();
      alt_auto_i <= r72();
      ext_drv <= r72() & r72();
      ext_val <= r72();
      bus_en_i <= bus;
      bus_wide_i <= 1'($random(seed));
      bus_drive_i <= 16'($random(seed));
      settle();
      p = {$random(seed)} % 9;
      op = {$random(seed)} % 6;
      d = 16'($random(seed));
      s = 2'($random(seed));
      if (bus && p < 2 && op == 1) d = 0;
      r = rv();
      wb(1, 12'(p * 32 + op * 4), d, s, q);
      for (j = 0; j < wd[p]; j++) begin
         i = bs[p] + j;
         if (s[j / 8]) begin
            case (op)
               0: m_lat[i] = d[j];
               1: m_dir[i] = d[j];
               2: if (p != 0) m_od[i] = d[j];
               3: m_lat[i] = r[i] | d[j];
               4: m_lat[i] = r[i] & ~d[j];
               default: m_lat[i] = r[i] ^ d[j];
            endcase
         end
      end
      settle();
      chk_all(p);
   endtask
   task automatic bitop();
      int i;
      logic [15:0] q;
      logic [71:0] r;
      i = {$random(seed)} % 72;
      m_lat[i] = 1'($random(seed));
      wb(1, 12'h400 + 12'(i * 4), {15'h0, m_lat[i]}, 1, q);
      settle();
      r = rv();
      wb(0, 12'h400 + 12'(i * 4), 0, 1, q);
      cmpr({15'h0, r[i]}, q);
      wb(0, 12'h400 + 12'((72 + {$random(seed)} % 100) * 4), 0, 1, q);
      cmpr(16'h0, q);
   endtask
   task automatic summarize();
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      logic [15:0] q;
      repeat (6) @(posedge clk_sys);
      rst <= 0;
      settle();
      for (int p = 0; p < 9; p++) chk_all(p);
      $display("reset test done");
      // Preload the latch before the drivers turn on, so no low glitch.
      wb(1, 12'(8 * 32), 16'h003f, 1, q);
      m_lat[71:66] = 6'h3f;
      wb(1, 12'(8 * 32 + 4), 16'h003f, 1, q);
      m_dir[71:66] = 6'h3f;
      settle();
      chk_all(8);
      $display("preload test done");
      repeat (150) step(0);
      $display("random port test done");
      @(posedge clk_sys);
      rst <= 1;
      {m_lat, m_dir, m_od} = '0;
      repeat (2) @(posedge clk_sys);
      rst <= 0;
      repeat (40) bitop();
      $display("bit area test done");
      repeat (40) step(1);
      $display("external bus test done");
      summarize();
   end
   initial begin
      #200000;
      n_fail++;
      summarize();
   end
endmodule
bind bpp_top bpp_top_monitor mon (.clk_sys(clk_sys), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
   .alt_sel_i(alt_sel_i), .alt_data_i(alt_data_i),
   .alt_auto_i(alt_auto_i), .alt_in_o(alt_in_o), .bus_en_i(bus_en_i),
   .bus_wide_i(bus_wide_i), .bus_drive_i(bus_drive_i));
